/* File: logic/spc_channel.sv */
`timescale 1ns/10ps
module spc_channel (
  input  logic                         sys_clk,
  input  logic                         nrst,
  input  logic                         rx_clk,
  input  logic [spc_pkg::SPC_WW-1:0]   rx_ser_word,
  input  logic                         cfg_bypass,
  input  logic                         cfg_half_rate,
  input  logic                         cfg_width10,
  input  logic                         cfg_rx_invert,
  input  logic                         cfg_tx_invert,
  input  logic                         rx_slip_req,
  output logic [2*spc_pkg::SPC_WW-1:0] rx_data,
  output logic                         rx_valid,
  output logic                         rx_locked,
  input  logic [2*spc_pkg::SPC_WW-1:0] tx_data,
  input  logic                         tx_valid,
  output logic                         tx_ready,
  output logic [spc_pkg::SPC_WW-1:0]   tx_word,
  output logic                         tx_word_valid,
  output logic                         rx_clk_half,
  output logic                         tx_clk_half
);
  import spc_pkg::*;

  // returns {running disparity after, abcdei fghj}; d[8] marks a K28 symbol
  function automatic logic [10:0] spc_enc(input logic [8:0] d, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic       r;
    logic       alt;
    c6 = d[8] ? SPC_K28_6B : SPC_TAB6[d[4:0]];
    if (rd && (d[8] || $countones(c6) != 3 || d[4:0] == 5'h07)) c6 = ~c6;
    r = rd ^ ($countones(c6) != 3);
    alt = (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
          (r && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e));
    c4 = d[8] ? SPC_TAB4K[d[7:5]] : (d[7:5] == 3'h7 && alt) ? SPC_ALT7 : SPC_TAB4[d[7:5]];
    if (r && (d[8] || $countones(c4) != 2 || d[7:5] == 3'h3)) c4 = ~c4;
    return {r ^ ($countones(c4) != 2), c6, c4};
  endfunction

  // returns {code error, k, data byte}; disparity is not checked
  function automatic logic [9:0] spc_dec(input logic [9:0] w);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [3:0] ref4;
    logic       k;
    logic       h6;
    logic       h4;
    logic [4:0] x;
    logic [2:0] y;
    c6 = w[9:4];
    c4 = w[3:0];
    k  = c6 == SPC_K28_6B || c6 == ~SPC_K28_6B;
    h6 = k;
    h4 = 1'b0;
    x  = k ? SPC_K28 : 5'h00;
    y  = 3'h0;
    for (int i = 0; i < 32; i++) begin
      if (!k && (c6 == SPC_TAB6[i] || (c6 == ~SPC_TAB6[i] &&
          ($countones(SPC_TAB6[i]) != 3 || i == 7)))) begin
        x  = 5'(i);
        h6 = 1'b1;
      end
    end
    for (int j = 0; j < 8; j++) begin
      ref4 = k ? ((c6 == SPC_K28_6B) ? ~SPC_TAB4K[j] : SPC_TAB4K[j]) : SPC_TAB4[j];
      if (c4 == ref4 || (!k && c4 == ~ref4 && ($countones(ref4) != 2 || j == 3))) begin
        y  = 3'(j);
        h4 = 1'b1;
      end
    end
    if (!k && (c4 == SPC_ALT7 || c4 == ~SPC_ALT7)) begin
      y  = 3'h7;
      h4 = 1'b1;
    end
    return {!(h6 && h4), k, y, x};
  endfunction

  spc_fifo_if fi ();

  spc_dsfifo u_fifo (
    .f (fi.store)
  );

  // ---------------- recovered clock domain ----------------
  logic        rrst1;
  logic        rrst_n;
  logic [2:0]  cfg_s1;
  logic [2:0]  cfg_rx;
  logic        slip_s1;
  logic        slip_s2;
  logic        slip_s3;
  logic        lock_rx;
  logic [3:0]  off;
  logic [9:0]  cur;
  logic [9:0]  prev;
  logic [9:0]  al_word;
  logic        al_ok;
  logic [9:0]  hit;
  logic [3:0]  hit_off;
  logic        slip_tgl;

  always_ff @(posedge rx_clk or negedge nrst) begin
    if (!nrst) begin
      rrst1  <= 1'b0;
      rrst_n <= 1'b0;
    end else begin
      rrst1  <= 1'b1;
      rrst_n <= rrst1;
    end
  end

  wire        byp_rx    = cfg_rx[2];
  wire        coded_rx  = !cfg_rx[2];
  wire        w10_rx    = cfg_rx[1] || coded_rx;
  wire [9:0]  rx_mask   = cfg_rx[0] ? (w10_rx ? SPC_MASK10 : SPC_MASK8) : SPC_WORD_RST;
  wire [19:0] hist      = {prev, cur};
  wire        slip_now  = slip_s2 ^ slip_s3;
  wire        found     = |hit;
  wire [4:0]  al_idx    = 5'h13 - {1'b0, off};
  wire [9:0]  aligned   = hist[al_idx -: 10];
  wire [9:0]  dec       = spc_dec(al_word);
  wire        skip_now  = coded_rx && !dec[9] && dec[8] && dec[7:0] == SPC_SKIP;
  wire        ctc_drop  = skip_now && fi.wr_count >= SPC_CTC_HIGH;
  wire [3:0]  next_off  = (off == SPC_OFF_MAX) ? SPC_OFF_RST : off + 4'h1;

  // comma search at the ten bit offsets 0 to 9 of the two-word history
  generate
    for (genvar o = 0; o < 10; o++) begin : g_comma
      assign hit[o] = hist[19-o -: 7] == SPC_COMMA || hist[19-o -: 7] == ~SPC_COMMA;
    end
  endgenerate

  always_comb begin
    hit_off = SPC_OFF_RST;
    for (int i = 9; i >= 0; i--) begin
      if (hit[i]) hit_off = 4'(i);
    end
  end

  assign fi.wclk    = rx_clk;
  assign fi.wrst_n  = rrst_n;
  // al_ok lags a mode change by one word, so lock is asked for again here
  assign fi.wr_en   = al_ok && (byp_rx || lock_rx) && !fi.full && !ctc_drop;
  assign fi.wr_data = coded_rx ? dec : al_word;

  always_ff @(posedge rx_clk or negedge rrst_n) begin
    if (!rrst_n) begin
      cfg_s1  <= 3'h0;
      cfg_rx  <= 3'h0;
      slip_s1 <= 1'b0;
      slip_s2 <= 1'b0;
      slip_s3 <= 1'b0;
    end else begin
      cfg_s1  <= {cfg_bypass, cfg_width10, cfg_rx_invert};
      cfg_rx  <= cfg_s1;
      slip_s1 <= slip_tgl;
      slip_s2 <= slip_s1;
      slip_s3 <= slip_s2;
    end
  end

  always_ff @(posedge rx_clk or negedge rrst_n) begin
    if (!rrst_n) begin
      cur         <= SPC_WORD_RST;
      prev        <= SPC_WORD_RST;
      al_word     <= SPC_WORD_RST;
      al_ok       <= 1'b0;
      rx_clk_half <= 1'b0;
    end else begin
      cur         <= rx_ser_word ^ rx_mask;
      prev        <= cur;
      al_word     <= w10_rx ? aligned : {2'b00, cur[7:0]};
      al_ok       <= byp_rx || lock_rx;
      rx_clk_half <= !rx_clk_half;
    end
  end

  always_ff @(posedge rx_clk or negedge rrst_n) begin
    if (!rrst_n) begin
      off     <= SPC_OFF_RST;
      lock_rx <= 1'b0;
    end else begin
      if (w10_rx && slip_now) off <= next_off;
      else if (coded_rx && !lock_rx && found) off <= hit_off;
      lock_rx <= coded_rx && (lock_rx || found);
    end
  end

  a_lock_gate: assert property (@(posedge rx_clk) disable iff (!rrst_n)
    fi.wr_en && coded_rx |-> $past(lock_rx))
    else $error("coded word entered fifo before comma lock");
  a_slip_step: assert property (@(posedge rx_clk) disable iff (!rrst_n)
    slip_now && w10_rx |=> off == (($past(off) == SPC_OFF_MAX) ? SPC_OFF_RST : $past(off) + 4'h1))
    else $error("bit slip did not move boundary by one");
  a_ctc_skip: assert property (@(posedge rx_clk) disable iff (!rrst_n)
    skip_now && fi.wr_count >= SPC_CTC_HIGH |-> !fi.wr_en)
    else $error("skip symbol written while fifo was filling");
  a_rx_clk_out: assert property (@(posedge rx_clk) disable iff (!rrst_n)
    rrst_n |=> rx_clk_half != $past(rx_clk_half))
    else $error("recovered clock output stopped toggling");
  c_lock: cover property (@(posedge rx_clk) disable iff (!rrst_n) $rose(lock_rx));
  c_drop: cover property (@(posedge rx_clk) disable iff (!rrst_n) ctc_drop);

  // ---------------- core clock domain ----------------
  logic        lk1;
  logic        rx_phase;
  logic [9:0]  rx_hold;
  logic        tx_phase;
  logic [9:0]  tx_hold;
  logic        tx_rd;

  assign fi.rclk   = sys_clk;
  assign fi.rrst_n = nrst;
  assign fi.rd_en  = !fi.empty;

  wire        pop      = !fi.empty;
  wire        accept   = tx_valid && tx_ready;
  wire        emit     = accept || tx_phase;
  wire [9:0]  lane     = tx_phase ? tx_hold : tx_data[9:0];
  wire [10:0] enc      = spc_enc(lane[8:0], tx_rd);
  wire        w10_tx   = cfg_width10 || !cfg_bypass;
  wire [9:0]  tx_mask  = cfg_tx_invert ? (w10_tx ? SPC_MASK10 : SPC_MASK8) : SPC_WORD_RST;
  wire [9:0]  tx_raw   = cfg_bypass ? (w10_tx ? lane : {2'b00, lane[7:0]}) : enc[9:0];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      slip_tgl  <= 1'b0;
      lk1       <= 1'b0;
      rx_locked <= 1'b0;
    end else begin
      if (rx_slip_req) slip_tgl <= !slip_tgl;
      lk1       <= lock_rx;
      rx_locked <= lk1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_data  <= {SPC_WORD_RST, SPC_WORD_RST};
      rx_valid <= 1'b0;
      rx_phase <= 1'b0;
      rx_hold  <= SPC_WORD_RST;
    end else begin
      rx_valid <= pop && (!cfg_half_rate || rx_phase);
      if (pop && !rx_phase && cfg_half_rate) rx_hold <= fi.rd_data;
      if (pop && !cfg_half_rate) rx_data <= {SPC_WORD_RST, fi.rd_data};
      if (pop && cfg_half_rate && rx_phase) rx_data <= {fi.rd_data, rx_hold};
      if (!cfg_half_rate) rx_phase <= 1'b0;
      else if (pop) rx_phase <= !rx_phase;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_word       <= SPC_WORD_RST;
      tx_word_valid <= 1'b0;
      tx_ready      <= 1'b0;
      tx_phase      <= 1'b0;
      tx_hold       <= SPC_WORD_RST;
      tx_rd         <= 1'b0;
      tx_clk_half   <= 1'b0;
    end else begin
      if (emit) tx_word <= tx_raw ^ tx_mask;
      tx_word_valid <= emit;
      if (emit && !cfg_bypass) tx_rd <= enc[10];
      tx_phase      <= accept && cfg_half_rate;
      if (accept) tx_hold <= tx_data[19:10];
      tx_ready      <= !(accept && cfg_half_rate);
      tx_clk_half   <= !tx_clk_half;
    end
  end

  a_codec_inverse: assert property (@(posedge sys_clk) disable iff (!nrst)
    tx_valid && (!tx_data[8] || tx_data[4:0] == SPC_K28) |->
      spc_dec(10'(spc_enc(tx_data[8:0], tx_rd))) == {1'b0, tx_data[8:0]})
    else $error("decode of encoded symbol does not return the input");
  a_tx_balance: assert property (@(posedge sys_clk) disable iff (!nrst)
    tx_word_valid && !$past(cfg_bypass) |-> $countones(tx_word) inside {4, 5, 6})
    else $error("encoded tx word is not near balanced");
  a_bypass_pass: assert property (@(posedge sys_clk) disable iff (!nrst)
    accept && cfg_bypass && cfg_width10 && !cfg_half_rate |=>
      tx_word == ($past(tx_data[9:0]) ^ {10{$past(cfg_tx_invert)}}))
    else $error("bypass tx word differs from core data");
  a_tx_width8: assert property (@(posedge sys_clk) disable iff (!nrst)
    emit && cfg_bypass && !cfg_width10 |=> tx_word[9:8] == 2'b00)
    else $error("8-bit tx word has upper bits set");
  a_half_pair: assert property (@(posedge sys_clk) disable iff (!nrst)
    accept && cfg_half_rate |=> (tx_word_valid && !tx_ready) ##1 (tx_word_valid && tx_ready))
    else $error("half rate transfer did not give two words");
  c_half_tx: cover property (@(posedge sys_clk) disable iff (!nrst) accept && cfg_half_rate);
  c_rx_word: cover property (@(posedge sys_clk) disable iff (!nrst) rx_valid && rx_locked);
endmodule

/* File: logic/spc_dsfifo.sv */
`timescale 1ns/10ps
module spc_dsfifo (
  spc_fifo_if.store f
);
  import spc_pkg::*;
  localparam int DEPTH = 1 << SPC_AW;

  logic [SPC_WW-1:0] mem [DEPTH];
  logic [SPC_AW:0]   wbin;
  logic [SPC_AW:0]   wgray;
  logic [SPC_AW:0]   rbin;
  logic [SPC_AW:0]   rgray;
  logic [SPC_AW:0]   rq1;
  logic [SPC_AW:0]   rq2;
  logic [SPC_AW:0]   wq1;
  logic [SPC_AW:0]   wq2;

  function automatic logic [SPC_AW:0] spc_g2b(input logic [SPC_AW:0] g);
    logic [SPC_AW:0] b;
    b = g;
    for (int i = SPC_AW - 1; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  wire             push      = f.wr_en && !f.full;
  wire             pop       = f.rd_en && !f.empty;
  wire [SPC_AW:0]  next_wbin = wbin + {{SPC_AW{1'b0}}, push};
  wire [SPC_AW:0]  next_rbin = rbin + {{SPC_AW{1'b0}}, pop};

  // gray pointers cross each way through two flops
  assign f.full     = wgray == {~rq2[SPC_AW:SPC_AW-1], rq2[SPC_AW-2:0]};
  assign f.empty    = rgray == wq2;
  assign f.wr_count = wbin - spc_g2b(rq2);
  assign f.rd_data  = mem[rbin[SPC_AW-1:0]];

  always_ff @(posedge f.wclk) begin
    if (push) mem[wbin[SPC_AW-1:0]] <= f.wr_data;
  end

  always_ff @(posedge f.wclk or negedge f.wrst_n) begin
    if (!f.wrst_n) begin
      wbin  <= '0;
      wgray <= '0;
      rq1   <= '0;
      rq2   <= '0;
    end else begin
      wbin  <= next_wbin;
      wgray <= next_wbin ^ (next_wbin >> 1);
      rq1   <= rgray;
      rq2   <= rq1;
    end
  end

  always_ff @(posedge f.rclk or negedge f.rrst_n) begin
    if (!f.rrst_n) begin
      rbin  <= '0;
      rgray <= '0;
      wq1   <= '0;
      wq2   <= '0;
    end else begin
      rbin  <= next_rbin;
      rgray <= next_rbin ^ (next_rbin >> 1);
      wq1   <= wgray;
      wq2   <= wq1;
    end
  end

  a_fifo_full_level: assert property (@(posedge f.wclk) disable iff (!f.wrst_n)
    f.full |-> f.wr_count == (SPC_AW+1)'(DEPTH))
    else $error("fifo full flag disagrees with fill level");
  a_fifo_push_step: assert property (@(posedge f.wclk) disable iff (!f.wrst_n)
    push |=> wbin == $past(wbin) + 1'b1)
    else $error("fifo write pointer did not advance on push");
  c_fifo_full: cover property (@(posedge f.wclk) disable iff (!f.wrst_n) f.full);
endmodule

/* File: logic/spc_fifo_if.sv */
`timescale 1ns/10ps
interface spc_fifo_if;
  import spc_pkg::*;
  logic              wclk;
  logic              rclk;
  logic              wrst_n;
  logic              rrst_n;
  logic              wr_en;
  logic [SPC_WW-1:0] wr_data;
  logic              full;
  logic [SPC_AW:0]   wr_count;
  logic              rd_en;
  logic [SPC_WW-1:0] rd_data;
  logic              empty;
  modport store (input wclk, rclk, wrst_n, rrst_n, wr_en, wr_data, rd_en,
                 output full, wr_count, rd_data, empty);
  modport user  (output wclk, rclk, wrst_n, rrst_n, wr_en, wr_data, rd_en,
                 input full, wr_count, rd_data, empty);
endinterface

/* File: logic/spc_pkg.sv */
package spc_pkg;
  localparam int          SPC_WW       = 10;
  localparam int          SPC_AW       = 3;
  localparam logic [3:0]  SPC_OFF_MAX  = 4'h9;
  localparam logic [3:0]  SPC_OFF_RST  = 4'h0;
  localparam logic [9:0]  SPC_WORD_RST = 10'h000;
  localparam logic [9:0]  SPC_MASK10   = 10'h3ff;
  localparam logic [9:0]  SPC_MASK8    = 10'h0ff;
  // first seven line bits of a comma, negative-disparity form
  localparam logic [6:0]  SPC_COMMA    = 7'h1f;
  localparam logic [5:0]  SPC_K28_6B   = 6'h0f;
  localparam logic [4:0]  SPC_K28      = 5'h1c;
  // clock tolerance compensation: skip symbol and fill level at which it is dropped
  localparam logic [7:0]  SPC_SKIP     = 8'h1c;
  localparam logic [3:0]  SPC_CTC_HIGH = 4'h6;
  // 5b/6b codes (abcdei) for negative running disparity
  localparam logic [5:0]  SPC_TAB6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  // 3b/4b codes (fghj) for negative running disparity
  localparam logic [3:0]  SPC_TAB4 [8]  = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  // 3b/4b codes after the K28 prefix, at negative running disparity
  localparam logic [3:0]  SPC_TAB4K [8] = '{4'hb, 4'h6, 4'ha, 4'hc, 4'hd, 4'h5, 4'h9, 4'h7};
  localparam logic [3:0]  SPC_ALT7     = 4'h7;
endpackage

/* File: verif/spc_serdes_model.sv */
`timescale 1ns/10ps
module spc_serdes_model (
  input  logic       rx_clk,
  input  logic       nrst,
  input  logic       mode,
  output logic [9:0] word
);
  // comma stream with correct running disparity: K28.5-, D21.5, K28.5+, D21.5
  localparam logic [9:0] SEQ [4] = '{10'h0fa, 10'h2aa, 10'h305, 10'h2aa};
  logic [1:0] idx;
  logic [9:0] cnt;
  // words change on the falling edge so the design samples them settled
  always @(negedge rx_clk or negedge nrst) begin
    if (!nrst) begin
      idx  <= 2'h0;
      cnt  <= 10'h000;
      word <= 10'h000;
    end else begin
      idx  <= idx + 2'h1;
      cnt  <= cnt + 10'h001;
      word <= mode ? cnt : SEQ[idx];
    end
  end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import spc_pkg::*;
  logic        sys_clk, nrst, rx_clk, ser_mode;
  logic [9:0]  rx_ser_word, tx_word;
  logic        cfg_bypass, cfg_half_rate, cfg_width10, cfg_rx_invert, cfg_tx_invert;
  logic        rx_slip_req, rx_valid, rx_locked, tx_valid, tx_ready, tx_word_valid;
  logic        rx_clk_half, tx_clk_half;
  logic [19:0] rx_data, tx_data;
  logic [9:0]  txq [$];
  logic [19:0] rxq [$];
  int          errors, compares;

  initial begin sys_clk = 1'b0; forever #2.5 sys_clk = ~sys_clk; end
  initial begin rx_clk = 1'b0; #1.3; forever #6 rx_clk = ~rx_clk; end

  spc_channel dut (.sys_clk(sys_clk), .nrst(nrst), .rx_clk(rx_clk), .rx_ser_word(rx_ser_word),
    .cfg_bypass(cfg_bypass), .cfg_half_rate(cfg_half_rate), .cfg_width10(cfg_width10),
    .cfg_rx_invert(cfg_rx_invert), .cfg_tx_invert(cfg_tx_invert), .rx_slip_req(rx_slip_req),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_locked(rx_locked), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word), .tx_word_valid(tx_word_valid),
    .rx_clk_half(rx_clk_half), .tx_clk_half(tx_clk_half));

  spc_serdes_model u_ser (.rx_clk(rx_clk), .nrst(nrst), .mode(ser_mode), .word(rx_ser_word));

  always @(posedge sys_clk) begin
    if (tx_word_valid === 1'b1) txq.push_back(tx_word);
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
  end

  task check(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task complete_run;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // holds the request until tx_ready is seen high at a rising edge, giving up after 20 rising edges
  task tx_put(input logic [19:0] d);
    int i;
    tx_data  = d;
    tx_valid = 1'b1;
    i = 0;
    do begin @(posedge sys_clk); i++; end while (tx_ready !== 1'b1 && i < 20);
    @(negedge sys_clk);
  endtask

  task rx_scan(output int good, output int bad);
    good = 0;
    bad  = 0;
    foreach (rxq[i]) begin
      if (rxq[i][9:0] === 10'h1bc || rxq[i][9:0] === 10'h0b5) good++;
      else bad++;
    end
  endtask

  task slip_pulse;
    rx_slip_req = 1'b1;
    cycles(1);
    rx_slip_req = 1'b0;
    cycles(20);
  endtask

  // K28.5, D21.5, K28.5 back to back: disparity flips the second comma
  task test_tx_coded;
    txq.delete();
    tx_put(20'h0_01bc);
    tx_put(20'h0_00b5);
    tx_put(20'h0_01bc);
    tx_valid = 1'b0;
    cycles(4);
    check(20'(txq.size()), 20'h0_0003);
    check({10'h0, txq[0]}, 20'h0_00fa);
    check({10'h0, txq[1]}, 20'h0_02aa);
    check({10'h0, txq[2]}, 20'h0_0305);
    $display("test tx_coded done");
  endtask

  task test_tx_half_invert;
    cfg_half_rate = 1'b1;
    cfg_tx_invert = 1'b1;
    cycles(4);
    txq.delete();
    tx_put({10'h0b5, 10'h1bc});
    check({19'h0, tx_ready}, 20'h0_0000);
    tx_put({10'h0b5, 10'h1bc});
    tx_valid = 1'b0;
    cycles(6);
    check(20'(txq.size()), 20'h0_0004);
    check({10'h0, txq[0]}, 20'h0_0305);
    check({10'h0, txq[1]}, 20'h0_0155);
    check({10'h0, txq[2]}, 20'h0_00fa);
    check({10'h0, txq[3]}, 20'h0_0155);
    $display("test tx_half_invert done");
  endtask

  task test_tx_bypass;
    cfg_half_rate = 1'b0;
    cfg_tx_invert = 1'b0;
    cfg_bypass    = 1'b1;
    for (int w = 1; w >= 0; w--) begin
      cfg_width10 = w[0];
      cycles(4);
      txq.delete();
      tx_put(20'h0_03c5);
      tx_valid = 1'b0;
      cycles(4);
      check(20'(txq.size()), 20'h0_0001);
      if (w == 1) check({10'h0, txq[0]}, 20'h0_03c5);
      else check({12'h0, txq[0][7:0]}, 20'h0_00c5);
    end
    cfg_bypass  = 1'b0;
    cfg_width10 = 1'b1;
    $display("test tx_bypass done");
  endtask

  // words gathered since reset: nothing unaligned may come out before lock
  task test_rx_coded;
    int good, bad;
    cycles(80);
    rx_scan(good, bad);
    check({19'h0, rx_locked}, 20'h0_0001);
    check(20'(bad), 20'h0_0000);
    check(20'(good >= 10), 20'h0_0001);
    $display("test rx_coded done");
  endtask

  task test_slip;
    int good, bad;
    // lock is taken again after bypass; a slip before that would be undone
    cycles(40);
    slip_pulse();
    rxq.delete();
    cycles(60);
    rx_scan(good, bad);
    check(20'(bad > 0), 20'h0_0001);
    repeat (9) slip_pulse();
    rxq.delete();
    cycles(60);
    rx_scan(good, bad);
    check(20'(bad), 20'h0_0000);
    check(20'(good >= 10), 20'h0_0001);
    $display("test slip done");
  endtask

  task test_rx_bypass;
    cfg_bypass    = 1'b1;
    cfg_half_rate = 1'b1;
    cfg_rx_invert = 1'b1;
    ser_mode      = 1'b1;
    cycles(30);
    rxq.delete();
    cycles(60);
    check(20'(rxq.size() > 5), 20'h0_0001);
    foreach (rxq[i]) check({10'h0, ~rxq[i][19:10]}, {10'h0, 10'(~rxq[i][9:0] + 10'h001)});
    cfg_half_rate = 1'b0;
    cfg_rx_invert = 1'b0;
    cfg_width10   = 1'b0;
    cycles(30);
    rxq.delete();
    cycles(60);
    check(20'(rxq.size() > 5), 20'h0_0001);
    for (int i = 0; i + 1 < rxq.size(); i++) begin
      check({8'h0, rxq[i][19:8]}, 20'h0_0000);
      check({12'h0, rxq[i + 1][7:0]}, {12'h0, 8'(rxq[i][7:0] + 8'h01)});
    end
    $display("test rx_bypass done");
  endtask

  task test_clocks;
    logic a;
    @(posedge sys_clk) a = tx_clk_half;
    @(posedge sys_clk) check({19'h0, tx_clk_half}, {19'h0, ~a});
    @(posedge rx_clk) a = rx_clk_half;
    @(posedge rx_clk) check({19'h0, rx_clk_half}, {19'h0, ~a});
    $display("test clocks done");
  endtask

  initial begin
    errors = 0; compares = 0; nrst = 1'b0; ser_mode = 1'b0; rx_slip_req = 1'b0;
    cfg_bypass = 1'b0; cfg_half_rate = 1'b0; cfg_width10 = 1'b1;
    cfg_rx_invert = 1'b0; cfg_tx_invert = 1'b0; tx_valid = 1'b0; tx_data = 20'h0_0000;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) nrst = 1'b1;
    cycles(2);
    test_rx_coded();
    test_tx_coded();
    test_tx_half_invert();
    test_tx_bypass();
    test_slip();
    test_rx_bypass();
    test_clocks();
    complete_run();
  end

  // the tests need about 700 core cycles; the limit leaves wide margin
  initial begin
    #50000;
    errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    complete_run();
  end
endmodule
